// *** core/litax_pkg.sv ***
/*
 * Constants and types for the long-address instruction core: widths,
 * instruction codes, timing and the fixed data memory addresses.
 * Assumes a single 50 MHz clock and that an instruction cycle is a fixed
 * number of clock periods.
 */
package litax_pkg;

  // Widths
  localparam int DATA_W = 8;
  localparam int DM_AW  = 9;
  localparam int PM_DW  = 16;
  localparam int PG_W   = 8;
  localparam int PM_AW  = 2 * PG_W;
  localparam int BIT_W  = 3;

  // Timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int INSTR_CYC_NS  = 80;
  localparam int CYC_DIV       = (INSTR_CYC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DIV_W         = 2;

  // Instruction cycle counts
  localparam logic [1:0] CYCLES_BASE = 2'h2;
  localparam logic [1:0] CYCLES_LONG = 2'h3;

  // Fixed addresses and values
  localparam logic [DM_AW-1:0]  PCL_ADDR   = 9'h007;
  localparam logic [PG_W-1:0]   LAST_PAGE  = 8'hff;
  localparam logic [DATA_W-1:0] BYTE_ZERO  = 8'h00;
  localparam logic [DATA_W-1:0] BYTE_ONES  = 8'hff;
  localparam logic [DATA_W-1:0] BYTE_ONE   = 8'h01;
  localparam logic [DATA_W-1:0] ACC_RST    = 8'h00;
  localparam logic [PG_W-1:0]   TABLE_POINTER_RST   = 8'h00;
  localparam logic [DATA_W-1:0] TABLE_HIGH_LATCH_RST   = 8'h00;

  typedef enum logic [4:0] {
    OP_NOP,
    OP_SKIP_IF_ZERO_LONG,
    OP_SKIP_IF_ZERO_COPY_LONG,
    OP_SKIP_IF_NONZERO_LONG,
    OP_SKIP_IF_ZERO_BIT_LONG,
    OP_SKIP_IF_NONZERO_BIT_LONG,
    OP_INCR_THEN_SKIP_LONG,
    OP_DECR_THEN_SKIP_LONG,
    OP_INCR_SKIP_TO_ACC_LONG,
    OP_DECR_SKIP_TO_ACC_LONG,
    OP_LONG_TABLE_FETCH_PAGE,
    OP_LONG_TABLE_FETCH_LAST,
    OP_LONG_TABLE_FETCH_PAGE_INC,
    OP_LONG_TABLE_FETCH_LAST_INC,
    OP_CLEAR_LONG,
    OP_FILL_LONG,
    OP_NIBBLE_EXCHANGE_LONG,
    OP_NIBBLE_EXCHANGE_TO_ACC_LONG,
    OP_ADD_WITH_CARRY,
    OP_ADD_WITH_CARRY_TO_MEM,
    OP_SUM,
    OP_SUM_TO_MEM,
    OP_SUM_IMM,
    OP_AND,
    OP_AND_IMM
  } litax_op_type;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_RUN
  } litax_state_type;

endpackage

// *** core/litax_dmem.sv ***
/*
 * Data memory of the long-address core: one write port and one read port,
 * read data registered.
 * Assumes reads and writes of the same cycle to the same address are not
 * relied on; the read returns the old byte.
 */
`timescale 1ns/100ps
module litax_dmem
  import litax_pkg::*;
(
  // Clock
  input  wire logic              clk,
  // Write port
  input  wire logic              wr_en,
  input  wire logic [DM_AW-1:0]  wr_addr,
  input  wire logic [DATA_W-1:0] wr_data,
  // Read port
  input  wire logic              rd_en,
  input  wire logic [DM_AW-1:0]  rd_addr,
  output logic      [DATA_W-1:0] rd_data_q
);

  logic [DATA_W-1:0] mem [0:(1<<DM_AW)-1];

  always_ff @(posedge clk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rd_en)
    begin
      rd_data_q <= mem[rd_addr];
    end
  end

endmodule

// *** core/litax_core.sv ***
/*
 * Long-address instruction core: extended skips, table fetches,
 * clear/fill, nibble exchange, add, add with carry and AND.
 * Assumes the issuer holds an instruction until INSTR_READY and that the
 * program memory returns PM_DATA within one instruction cycle of PM_ADDR.
 */
`timescale 1ns/100ps
module litax_core
  import litax_pkg::*;
(
  // Clock and reset
  input  wire logic              MCLK,
  input  wire logic              RESET,
  // Instruction issue
  input  wire logic              INSTR_VALID,
  output logic                   INSTR_READY,
  input  wire litax_op_type      INSTR_OP,
  input  wire logic [DM_AW-1:0]  INSTR_ADDR,
  input  wire logic [BIT_W-1:0]  INSTR_BIT,
  input  wire logic [DATA_W-1:0] INSTR_IMM,
  input  wire logic [PG_W-1:0]   INSTR_PAGE,
  // Completion
  output logic                   CYCLE_TICK,
  output logic                   INSTR_DONE,
  output logic                   INSTR_SKIP,
  output logic                   PCL_LOAD,
  // Program memory
  output logic      [PM_AW-1:0]  PM_ADDR,
  input  wire logic [PM_DW-1:0]  PM_DATA,
  // Core state
  output logic      [DATA_W-1:0] ACC,
  output logic                   FLAG_C,
  output logic                   FLAG_AC,
  output logic                   FLAG_Z,
  output logic                   FLAG_OV,
  output logic                   FLAG_SC,
  output logic      [DATA_W-1:0] TBL_HIGH,
  output logic      [PG_W-1:0]   TBL_PTR
);

  // Returns {ov, ac, c, sum}
  function automatic logic [DATA_W+2:0] add8(input logic [DATA_W-1:0] a,
                                             input logic [DATA_W-1:0] b,
                                             input logic              cin);
    logic [DATA_W:0] full;
    logic [4:0]      low;
    logic            ov;
    full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    low  = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    ov   = (a[7] == b[7]) && (full[7] != a[7]);
    return {ov, low[4], full[8], full[7:0]};
  endfunction

  function automatic logic is_table(input litax_op_type op);
    return (op == OP_LONG_TABLE_FETCH_PAGE) || (op == OP_LONG_TABLE_FETCH_LAST) ||
           (op == OP_LONG_TABLE_FETCH_PAGE_INC) || (op == OP_LONG_TABLE_FETCH_LAST_INC);
  endfunction

  litax_state_type   state_q;
  logic [DIV_W-1:0]  div_q;
  logic              cyc_en;
  logic [1:0]        cnt_q;
  logic [1:0]        need_q;
  litax_op_type      op_q;
  logic [DM_AW-1:0]  addr_q;
  logic [BIT_W-1:0]  bit_q;
  logic [DATA_W-1:0] imm_q;
  logic [PG_W-1:0]   page_q;
  logic [DATA_W-1:0] acc_q;
  logic              c_q;
  logic              ac_q;
  logic              z_q;
  logic              ov_q;
  logic              sc_q;
  logic [PG_W-1:0]   table_pointer_q;
  logic [DATA_W-1:0] table_high_latch_q;
  logic [PM_AW-1:0]  pm_addr_q;
  logic              skip_q;
  logic              done_q;
  logic              skip_out_q;
  logic              pcl_q;
  logic [DATA_W-1:0] mem_rd;
  logic              accept;
  logic              exec;
  logic              finish;
  logic              tab_wr;

  // Execution results
  logic [DATA_W-1:0] res;
  logic              wr_mem;
  logic              wr_acc;
  logic              upd_arith;
  logic              upd_z;
  logic              skip;
  logic [DATA_W+2:0] sum;
  logic [1:0]        need_d;

  // One enable per instruction cycle
  always_ff @(posedge MCLK or posedge RESET)
  begin
    if (RESET)
    begin
      div_q <= '0;
    end
    else if (div_q == DIV_W'(CYC_DIV - 1))
    begin
      div_q <= '0;
    end
    else
    begin
      div_q <= div_q + 2'h1;
    end
  end

  assign cyc_en      = (div_q == DIV_W'(CYC_DIV - 1));
  assign INSTR_READY = (state_q == ST_IDLE) && cyc_en;
  assign accept      = INSTR_VALID && INSTR_READY;
  assign exec        = (state_q == ST_RUN) && cyc_en && (cnt_q == 2'h1);
  // Two-cycle ops end on the deciding tick itself, before need_q is loaded
  assign finish      = (state_q == ST_RUN) && cyc_en &&
                       (exec ? (need_d == CYCLES_BASE) : (cnt_q == need_q - 2'h1));
  assign tab_wr      = finish && is_table(op_q);

  // Cycle sequencing
  always_ff @(posedge MCLK or posedge RESET)
  begin
    if (RESET)
    begin
      state_q <= ST_IDLE;
      cnt_q   <= 2'h0;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          if (accept)
          begin
            state_q <= ST_RUN;
            cnt_q   <= 2'h1;
          end
        end
        ST_RUN:
        begin
          if (finish)
          begin
            state_q <= ST_IDLE;
          end
          else if (cyc_en)
          begin
            cnt_q <= cnt_q + 2'h1;
          end
        end
        default:
        begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge MCLK or posedge RESET)
  begin
    if (RESET)
    begin
      op_q   <= OP_NOP;
      addr_q <= '0;
      bit_q  <= '0;
      imm_q  <= '0;
      page_q <= '0;
    end
    else if (accept)
    begin
      op_q   <= INSTR_OP;
      addr_q <= INSTR_ADDR;
      bit_q  <= INSTR_BIT;
      imm_q  <= INSTR_IMM;
      page_q <= INSTR_PAGE;
    end
  end

  litax_dmem u_dmem (
    .clk       (MCLK),
    .wr_en     ((exec && wr_mem) || tab_wr),
    .wr_addr   (addr_q),
    .wr_data   (tab_wr ? PM_DATA[DATA_W-1:0] : res),
    .rd_en     (accept),
    .rd_addr   (INSTR_ADDR),
    .rd_data_q (mem_rd)
  );

  always_comb
  begin
    res       = mem_rd;
    wr_mem    = 1'b0;
    wr_acc    = 1'b0;
    upd_arith = 1'b0;
    upd_z     = 1'b0;
    skip      = 1'b0;
    sum       = add8(acc_q, mem_rd, 1'b0);
    case (op_q)
      OP_SKIP_IF_ZERO_LONG:
      begin
        skip = (mem_rd == BYTE_ZERO);
      end
      OP_SKIP_IF_ZERO_COPY_LONG:
      begin
        wr_acc = 1'b1;
        skip   = (mem_rd == BYTE_ZERO);
      end
      OP_SKIP_IF_NONZERO_LONG:
      begin
        skip = (mem_rd != BYTE_ZERO);
      end
      OP_SKIP_IF_ZERO_BIT_LONG:
      begin
        skip = !mem_rd[bit_q];
      end
      OP_SKIP_IF_NONZERO_BIT_LONG:
      begin
        skip = mem_rd[bit_q];
      end
      OP_INCR_THEN_SKIP_LONG, OP_INCR_SKIP_TO_ACC_LONG:
      begin
        res    = mem_rd + BYTE_ONE;
        wr_mem = (op_q == OP_INCR_THEN_SKIP_LONG);
        wr_acc = (op_q == OP_INCR_SKIP_TO_ACC_LONG);
        skip   = (res == BYTE_ZERO);
      end
      OP_DECR_THEN_SKIP_LONG, OP_DECR_SKIP_TO_ACC_LONG:
      begin
        res    = mem_rd - BYTE_ONE;
        wr_mem = (op_q == OP_DECR_THEN_SKIP_LONG);
        wr_acc = (op_q == OP_DECR_SKIP_TO_ACC_LONG);
        skip   = (res == BYTE_ZERO);
      end
      OP_CLEAR_LONG:
      begin
        res    = BYTE_ZERO;
        wr_mem = 1'b1;
      end
      OP_FILL_LONG:
      begin
        res    = BYTE_ONES;
        wr_mem = 1'b1;
      end
      OP_NIBBLE_EXCHANGE_LONG, OP_NIBBLE_EXCHANGE_TO_ACC_LONG:
      begin
        res    = {mem_rd[3:0], mem_rd[7:4]};
        wr_mem = (op_q == OP_NIBBLE_EXCHANGE_LONG);
        wr_acc = (op_q == OP_NIBBLE_EXCHANGE_TO_ACC_LONG);
      end
      OP_ADD_WITH_CARRY, OP_ADD_WITH_CARRY_TO_MEM:
      begin
        sum       = add8(acc_q, mem_rd, c_q);
        res       = sum[DATA_W-1:0];
        wr_mem    = (op_q == OP_ADD_WITH_CARRY_TO_MEM);
        wr_acc    = (op_q == OP_ADD_WITH_CARRY);
        upd_arith = 1'b1;
      end
      OP_SUM, OP_SUM_TO_MEM:
      begin
        res       = sum[DATA_W-1:0];
        wr_mem    = (op_q == OP_SUM_TO_MEM);
        wr_acc    = (op_q == OP_SUM);
        upd_arith = 1'b1;
      end
      OP_SUM_IMM:
      begin
        sum       = add8(acc_q, imm_q, 1'b0);
        res       = sum[DATA_W-1:0];
        wr_acc    = 1'b1;
        upd_arith = 1'b1;
      end
      OP_AND, OP_AND_IMM:
      begin
        res    = acc_q & ((op_q == OP_AND_IMM) ? imm_q : mem_rd);
        wr_acc = 1'b1;
        upd_z  = 1'b1;
      end
      default:
      begin
        res = mem_rd;
      end
    endcase
  end

  // Length decided in the first cycle, once the operand is known
  always_comb
  begin
    need_d = CYCLES_BASE;
    if (skip)
    begin
      need_d = CYCLES_LONG;
    end
    if (wr_mem && (addr_q == PCL_ADDR))
    begin
      need_d = CYCLES_LONG;
    end
    if (is_table(op_q))
    begin
      need_d = CYCLES_LONG;
    end
  end

  // Held at three until the operand is known so finish cannot fire early
  always_ff @(posedge MCLK or posedge RESET)
  begin
    if (RESET)
    begin
      need_q <= CYCLES_LONG;
      skip_q <= 1'b0;
    end
    else if (accept)
    begin
      need_q <= CYCLES_LONG;
      skip_q <= 1'b0;
    end
    else if (exec)
    begin
      need_q <= need_d;
      skip_q <= skip;
    end
  end

  always_ff @(posedge MCLK or posedge RESET)
  begin
    if (RESET)
    begin
      acc_q <= ACC_RST;
    end
    else if (exec && wr_acc)
    begin
      acc_q <= res;
    end
  end

  // Skips, table fetches and nibble exchanges leave every flag alone
  always_ff @(posedge MCLK or posedge RESET)
  begin
    if (RESET)
    begin
      c_q  <= 1'b0;
      ac_q <= 1'b0;
      z_q  <= 1'b0;
      ov_q <= 1'b0;
      sc_q <= 1'b0;
    end
    else if (exec && upd_arith)
    begin
      ov_q <= sum[DATA_W+2];
      ac_q <= sum[DATA_W+1];
      c_q  <= sum[DATA_W];
      z_q  <= (sum[DATA_W-1:0] == BYTE_ZERO);
      sc_q <= sum[DATA_W+2] ^ sum[DATA_W-1];
    end
    else if (exec && upd_z)
    begin
      z_q <= (res == BYTE_ZERO);
    end
  end

  // Pointer bumped at issue, before the page address is formed
  always_ff @(posedge MCLK or posedge RESET)
  begin
    if (RESET)
    begin
      table_pointer_q <= TABLE_POINTER_RST;
    end
    else if (accept && ((INSTR_OP == OP_LONG_TABLE_FETCH_PAGE_INC) ||
                        (INSTR_OP == OP_LONG_TABLE_FETCH_LAST_INC)))
    begin
      table_pointer_q <= table_pointer_q + 8'h01;
    end
  end

  always_ff @(posedge MCLK or posedge RESET)
  begin
    if (RESET)
    begin
      pm_addr_q <= '0;
    end
    else if (exec && is_table(op_q))
    begin
      if ((op_q == OP_LONG_TABLE_FETCH_LAST) || (op_q == OP_LONG_TABLE_FETCH_LAST_INC))
      begin
        pm_addr_q <= {LAST_PAGE, table_pointer_q};
      end
      else
      begin
        pm_addr_q <= {page_q, table_pointer_q};
      end
    end
  end

  always_ff @(posedge MCLK or posedge RESET)
  begin
    if (RESET)
    begin
      table_high_latch_q <= TABLE_HIGH_LATCH_RST;
    end
    else if (tab_wr)
    begin
      table_high_latch_q <= PM_DATA[PM_DW-1:DATA_W];
    end
  end

  always_ff @(posedge MCLK or posedge RESET)
  begin
    if (RESET)
    begin
      done_q     <= 1'b0;
      skip_out_q <= 1'b0;
      pcl_q      <= 1'b0;
    end
    else
    begin
      done_q     <= finish;
      skip_out_q <= finish && skip_q;
      pcl_q      <= (exec && wr_mem && (addr_q == PCL_ADDR)) ||
                    (tab_wr && (addr_q == PCL_ADDR));
    end
  end

  assign CYCLE_TICK = cyc_en;
  assign INSTR_DONE = done_q;
  assign INSTR_SKIP = skip_out_q;
  assign PCL_LOAD   = pcl_q;
  assign PM_ADDR    = pm_addr_q;
  assign ACC        = acc_q;
  assign FLAG_C     = c_q;
  assign FLAG_AC    = ac_q;
  assign FLAG_Z     = z_q;
  assign FLAG_OV    = ov_q;
  assign FLAG_SC    = sc_q;
  assign TBL_HIGH   = table_high_latch_q;
  assign TBL_PTR    = table_pointer_q;

endmodule

// *** dv/litax_monitor.sv ***
/*
 * Checker for the long-address core: issue spacing, completion timing,
 * skip length, flag retention and table pointer bump.
 * Assumes it is bound to litax_core and sees only its ports.
 */
`timescale 1ns/100ps
module litax_monitor
  import litax_pkg::*;
(
  // Clock and reset
  input wire logic            MCLK,
  input wire logic            RESET,
  // Issue and completion
  input wire logic            INSTR_VALID,
  input wire logic            INSTR_READY,
  input wire litax_op_type    INSTR_OP,
  input wire logic            CYCLE_TICK,
  input wire logic            INSTR_DONE,
  input wire logic            INSTR_SKIP,
  // Core state
  input wire logic            FLAG_C,
  input wire logic            FLAG_AC,
  input wire logic            FLAG_Z,
  input wire logic            FLAG_OV,
  input wire logic            FLAG_SC,
  input wire logic [PG_W-1:0] TBL_PTR
);
  default clocking @(posedge MCLK);
  endclocking
  default disable iff (RESET);

  sequence s_take;
    INSTR_VALID && INSTR_READY;
  endsequence
  sequence s_two;
    !INSTR_DONE [*4] ##1 INSTR_DONE;
  endsequence
  sequence s_three;
    !INSTR_DONE [*8] ##1 INSTR_DONE;
  endsequence

  a_ready_on_tick: assert property (INSTR_READY |-> CYCLE_TICK)
    else $error("ready outside an instruction cycle tick");
  a_tick_spacing: assert property (CYCLE_TICK |=> !CYCLE_TICK [*3] ##1 CYCLE_TICK)
    else $error("instruction cycle tick spacing wrong");
  a_done_timing: assert property (s_take |=> s_two or s_three)
    else $error("completion not after two or three cycles");
  a_busy_refuse: assert property (s_take |=> !INSTR_READY [*7])
    else $error("ready while busy");
  a_skip_three: assert property (INSTR_SKIP |->
      INSTR_DONE && $past(INSTR_READY, 9) && !$past(INSTR_READY, 5))
    else $error("skip not on a three cycle completion");
  a_flags_kept: assert property (s_take ##0
      (INSTR_OP inside {[OP_SKIP_IF_ZERO_LONG:OP_NIBBLE_EXCHANGE_TO_ACC_LONG]})
      |=> $stable({FLAG_C, FLAG_AC, FLAG_Z, FLAG_OV, FLAG_SC}) [*8])
    else $error("flags changed by a flag-free instruction");
  a_and_z_only: assert property (s_take ##0
      (INSTR_OP inside {OP_AND, OP_AND_IMM})
      |=> $stable({FLAG_C, FLAG_AC, FLAG_OV, FLAG_SC}) [*8])
    else $error("logical and touched a flag other than zero");
  a_ptr_bump: assert property (s_take ##0
      (INSTR_OP inside {OP_LONG_TABLE_FETCH_PAGE_INC, OP_LONG_TABLE_FETCH_LAST_INC})
      |=> TBL_PTR == $past(TBL_PTR) + 8'h01)
    else $error("table pointer not bumped at take");
endmodule

bind litax_core litax_monitor u_mon (
  .MCLK        (MCLK),
  .RESET       (RESET),
  .INSTR_VALID (INSTR_VALID),
  .INSTR_READY (INSTR_READY),
  .INSTR_OP    (INSTR_OP),
  .CYCLE_TICK  (CYCLE_TICK),
  .INSTR_DONE  (INSTR_DONE),
  .INSTR_SKIP  (INSTR_SKIP),
  .FLAG_C      (FLAG_C),
  .FLAG_AC     (FLAG_AC),
  .FLAG_Z      (FLAG_Z),
  .FLAG_OV     (FLAG_OV),
  .FLAG_SC     (FLAG_SC),
  .TBL_PTR     (TBL_PTR)
);

// *** dv/long_instr_timing_and_add_logic_tb_top.sv ***
/*
 * Self-checking bench for litax_core: every opcode, add corners, then
 * random instructions compared against a model of the core state.
 * Assumes program memory answers with a fixed function of its address.
 */
`timescale 1ns/100ps
module long_instr_timing_and_add_logic_tb_top
  import litax_pkg::*;
  ;
  logic              mclk, reset, valid, ready, tick, done, skip, program_counter_low;
  litax_op_type      op;
  logic [DM_AW-1:0]  addr;
  logic [BIT_W-1:0]  bsel;
  logic [DATA_W-1:0] imm, acc, tbh, m_acc, m_tbh;
  logic [PG_W-1:0]   page, tbp, m_tbp;
  logic [PM_AW-1:0]  pm_addr, m_pma;
  logic [PM_DW-1:0]  pm_data;
  logic [4:0]        flags, m_f;
  logic [DATA_W-1:0] m_mem [512];
  logic [DM_AW-1:0]  pool [4] = '{9'h007, 9'h055, 9'h100, 9'h1ff};
  logic [31:0]       seed = 32'ha42c;
  int                errors = 0;
  int                n_compared = 0;

  litax_core uut (
    .MCLK (mclk), .RESET (reset), .INSTR_VALID (valid), .INSTR_READY (ready),
    .INSTR_OP (op), .INSTR_ADDR (addr), .INSTR_BIT (bsel), .INSTR_IMM (imm),
    .INSTR_PAGE (page), .CYCLE_TICK (tick), .INSTR_DONE (done), .INSTR_SKIP (skip),
    .PCL_LOAD (program_counter_low), .PM_ADDR (pm_addr), .PM_DATA (pm_data), .ACC (acc),
    .FLAG_C (flags[4]), .FLAG_AC (flags[3]), .FLAG_Z (flags[2]), .FLAG_OV (flags[1]),
    .FLAG_SC (flags[0]), .TBL_HIGH (tbh), .TBL_PTR (tbp)
  );

  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [15:0] pm_word(input logic [15:0] a);
    return {a[7:0] ^ a[15:8], a[7:0] + 8'h3c};
  endfunction

  // Program memory answers the current address at each falling clock edge
  always @(negedge mclk) pm_data <= pm_word(pm_addr);

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Opcode pairs differ in bit 0, see the enum order
  task automatic predict(input litax_op_type o, input logic [DM_AW-1:0] a,
                         input logic [BIT_W-1:0] bi, input logic [7:0] im, pg,
                         output int need, output logic skp, output logic wr);
    logic [8:0] s;
    logic [4:0] h;
    logic [7:0] v;
    logic [7:0] b;
    logic       c;
    logic       ov;
    v = m_mem[a];
    skp = 1'b0;
    wr = 1'b0;
    case (o) inside
      OP_SKIP_IF_ZERO_LONG: skp = v == 8'h00;
      OP_SKIP_IF_NONZERO_LONG: skp = v != 8'h00;
      OP_SKIP_IF_ZERO_BIT_LONG: skp = !v[bi];
      OP_SKIP_IF_NONZERO_BIT_LONG: skp = v[bi];
      OP_SKIP_IF_ZERO_COPY_LONG:
      begin
        m_acc = v;
        skp = v == 8'h00;
      end
      [OP_INCR_THEN_SKIP_LONG:OP_DECR_SKIP_TO_ACC_LONG]:
      begin
        v = o[0] ? v - 8'h01 : v + 8'h01;
        skp = v == 8'h00;
        wr = o <= OP_DECR_THEN_SKIP_LONG;
        if (!wr)
          m_acc = v;
      end
      [OP_LONG_TABLE_FETCH_PAGE:OP_LONG_TABLE_FETCH_LAST_INC]:
      begin
        if (o >= OP_LONG_TABLE_FETCH_PAGE_INC)
          m_tbp = m_tbp + 8'h01;
        m_pma = {o[0] ? LAST_PAGE : pg, m_tbp};
        {m_tbh, v} = pm_word(m_pma);
        wr = 1'b1;
      end
      [OP_CLEAR_LONG:OP_FILL_LONG]:
      begin
        v = {8{o[0]}};
        wr = 1'b1;
      end
      [OP_NIBBLE_EXCHANGE_LONG:OP_NIBBLE_EXCHANGE_TO_ACC_LONG]:
      begin
        v = {v[3:0], v[7:4]};
        wr = !o[0];
        if (o[0])
          m_acc = v;
      end
      [OP_ADD_WITH_CARRY:OP_SUM_IMM]:
      begin
        b = (o == OP_SUM_IMM) ? im : v;
        c = o <= OP_ADD_WITH_CARRY_TO_MEM && m_f[4];
        s = m_acc + b + c;
        h = m_acc[3:0] + b[3:0] + c;
        ov = m_acc[7] == b[7] && s[7] != m_acc[7];
        m_f = {s[8], h[4], s[7:0] == 8'h00, ov, ov ^ s[7]};
        wr = o == OP_ADD_WITH_CARRY_TO_MEM || o == OP_SUM_TO_MEM;
        if (!wr)
          m_acc = s[7:0];
        v = s[7:0];
      end
      [OP_AND:OP_AND_IMM]:
      begin
        m_acc = m_acc & ((o == OP_AND) ? v : im);
        m_f[2] = m_acc == 8'h00;
      end
      default: ;
    endcase
    if (wr)
      m_mem[a] = v;
    need = (skp || o inside {[OP_LONG_TABLE_FETCH_PAGE:OP_LONG_TABLE_FETCH_LAST_INC]}
            || (wr && a == PCL_ADDR)) ? 3 : 2;
  endtask

  task automatic run(input litax_op_type o, input logic [DM_AW-1:0] a,
                     input logic [BIT_W-1:0] bi, input logic [7:0] im, pg);
    int   k;
    int   need;
    int   np;
    logic skp;
    logic wr;
    @(negedge mclk);
    op = o;
    addr = a;
    bsel = bi;
    imm = im;
    page = pg;
    valid = 1'b1;
    k = 0;
    while (ready !== 1'b1 && k < 8)
    begin
      @(negedge mclk);
      k++;
    end
    predict(o, a, bi, im, pg, need, skp, wr);
    @(negedge mclk);
    valid = 1'b0;
    np = 0;
    for (k = 1; k < 13 && done !== 1'b1; k++)
    begin
      np += (program_counter_low === 1'b1);
      @(negedge mclk);
    end
    np += (program_counter_low === 1'b1);
    check(k, 4 * (need - 1) + 1);
    check(skip, skp);
    check(acc, m_acc);
    check(flags, m_f);
    check({tbh, tbp}, {m_tbh, m_tbp});
    if (o inside {[OP_LONG_TABLE_FETCH_PAGE:OP_LONG_TABLE_FETCH_LAST_INC]})
      check(pm_addr, m_pma);
    @(negedge mclk);
    np += (program_counter_low === 1'b1);
    check(np, wr && a == PCL_ADDR);
  endtask

  initial
  begin
    reset = 1'b1;
    valid = 1'b0;
    op = OP_NOP;
    addr = '0;
    bsel = '0;
    imm = '0;
    page = '0;
    m_acc = ACC_RST;
    m_tbh = TABLE_HIGH_LATCH_RST;
    m_tbp = TABLE_POINTER_RST;
    m_f = '0;
    m_pma = '0;
    repeat (8) @(negedge mclk);
    reset = 1'b0;
    check({acc, tbh, tbp, flags}, '0);
    run(OP_FILL_LONG, 9'h100, 3'h0, 8'h00, 8'h00);
    run(OP_CLEAR_LONG, 9'h055, 3'h0, 8'h00, 8'h00);
    run(OP_LONG_TABLE_FETCH_PAGE, 9'h1ff, 3'h0, 8'h00, 8'h12);
    run(OP_LONG_TABLE_FETCH_LAST_INC, PCL_ADDR, 3'h0, 8'h00, 8'h00);
    $display("test init done");
    for (int i = 0; i < 25; i++)
      run(litax_op_type'(i), pool[i % 4], 3'(i), 8'(i * 37), 8'(i));
    $display("test opcodes done");
    // Wrap to zero, signed overflow and carry chaining
    run(OP_FILL_LONG, 9'h100, 3'h0, 8'h00, 8'h00);
    run(OP_INCR_THEN_SKIP_LONG, 9'h100, 3'h0, 8'h00, 8'h00);
    run(OP_DECR_SKIP_TO_ACC_LONG, 9'h100, 3'h0, 8'h00, 8'h00);
    run(OP_AND_IMM, 9'h000, 3'h0, 8'h00, 8'h00);
    run(OP_SUM_IMM, 9'h000, 3'h0, 8'h7f, 8'h00);
    run(OP_SUM_IMM, 9'h000, 3'h0, 8'h01, 8'h00);
    run(OP_SUM_IMM, 9'h000, 3'h0, 8'h80, 8'h00);
    run(OP_ADD_WITH_CARRY_TO_MEM, 9'h055, 3'h0, 8'h00, 8'h00);
    $display("test corners done");
    for (int i = 0; i < 300; i++)
    begin
      seed = lfsr(seed);
      run(litax_op_type'(seed[7:0] % 8'd25), pool[seed[9:8]], seed[12:10], seed[20:13],
          seed[28:21]);
    end
    $display("test random done");
    complete_run();
  end

  // Roughly five times the expected run length
  initial
  begin
    #300000;
    errors++;
    complete_run();
  end
endmodule
